// ===== verilog/rec_pkg.sv
// Overview of operation
// - Reference control bit 6 enables external reference monitor; resets to 0.
// - Reference control bit 5 bypasses positive reference buffer; resets to 0.
// - Reference control bit 4 bypasses negative reference buffer; resets to 1.
// - Bits 3:2 pick reference: first pair, second pair, internal, reserved.
// - Bits 1:0 internal reference: off, on but sleeps, always on, reserved.
// - Magnitude bits 3:0 set both excitation sources to one common value.
// - Codes 1 to 9 give 10 to 2000 uA; 0 and above 9 off.
// - Magnitude register at 06h, reset 00h, upper four bits reserved.
// - Routing register at 07h, reset FFh, both outputs disconnected.
// - Reference control register at 05h, reset 10h, bit 7 reserved.
`default_nettype none

package rec_pkg;

    localparam int REC_ADDR_W = 8;
    localparam int REC_DATA_W = 32;
    localparam int REC_UA_W   = 12;

    localparam logic [5:0] REC_IDX_REF    = 6'h05;
    localparam logic [5:0] REC_IDX_MAG    = 6'h06;
    localparam logic [5:0] REC_IDX_ROUTE  = 6'h07;
    localparam logic [5:0] REC_IDX_STATUS = 6'h10;

    localparam logic [7:0] REC_RST_REF   = 8'h10;
    localparam logic [7:0] REC_RST_MAG   = 8'h00;
    localparam logic [7:0] REC_RST_ROUTE = 8'hff;

    localparam int REC_BIT_REF_RSVD = 7;
    localparam int REC_BIT_MON      = 6;
    localparam int REC_BIT_PBUF     = 5;
    localparam int REC_BIT_NBUF     = 4;
    localparam int REC_SEL_LSB      = 2;
    localparam int REC_CON_LSB      = 0;
    localparam int REC_MAG_LSB      = 0;
    localparam int REC_ROUTE1_LSB   = 0;
    localparam int REC_ROUTE2_LSB   = 4;

    localparam logic [3:0] REC_MAG_RSVD_MASK = 4'hf;

    typedef enum logic [1:0] {
        REC_SEL_FIRST    = 2'h0,
        REC_SEL_SECOND   = 2'h1,
        REC_SEL_INTERNAL = 2'h2,
        REC_SEL_RESERVED = 2'h3
    } rec_refsel_t;

    typedef enum logic [1:0] {
        REC_CON_OFF      = 2'h0,
        REC_CON_ON_SLEEP = 2'h1,
        REC_CON_ALWAYS   = 2'h2,
        REC_CON_RESERVED = 2'h3
    } rec_refcon_t;

    localparam int REC_ST_REF_ON    = 0;
    localparam int REC_ST_SEL_RSVD  = 1;
    localparam int REC_ST_CON_RSVD  = 2;
    localparam int REC_ST_SRC_NOREF = 3;
    localparam int REC_ST_INT_BUF   = 4;
    localparam int REC_ST_RSVD_SET  = 5;
    localparam int REC_ST_SRC_ON    = 6;

    localparam logic [1:0] REC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] REC_RESP_SLVERR = 2'h2;

    typedef enum logic {
        REC_RD_IDLE = 1'b0,
        REC_RD_RESP = 1'b1
    } rec_rd_state_t;

endpackage : rec_pkg

`default_nettype wire

// ===== verilog/rec_regbus_if.sv
`default_nettype none

interface rec_regbus_if;
    import rec_pkg::*;

    logic                    wr_en;
    logic [REC_ADDR_W-1:0]   wr_addr;
    logic [REC_DATA_W-1:0]   wr_data;
    logic [REC_DATA_W/8-1:0] wr_strb;
    logic                    wr_ok;
    logic [REC_ADDR_W-1:0]   rd_addr;
    logic [REC_DATA_W-1:0]   rd_data;
    logic                    rd_ok;

    modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                   input  wr_ok, rd_data, rd_ok);
    modport bank  (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                   output wr_ok, rd_data, rd_ok);

endinterface : rec_regbus_if

`default_nettype wire

// ===== verilog/rec_idac_decode.sv
`default_nettype none

module rec_idac_decode
    import rec_pkg::*;
(
    input  wire logic [3:0]          code,
    output logic      [REC_UA_W-1:0] microamps,
    output logic                     active
);

    always_comb begin
        case (code)
            4'h1:    microamps = 12'd10;
            4'h2:    microamps = 12'd50;
            4'h3:    microamps = 12'd100;
            4'h4:    microamps = 12'd250;
            4'h5:    microamps = 12'd500;
            4'h6:    microamps = 12'd750;
            4'h7:    microamps = 12'd1000;
            4'h8:    microamps = 12'd1500;
            4'h9:    microamps = 12'd2000;
            default: microamps = 12'd0;
        endcase
        active = (microamps != 12'd0);
    end

endmodule : rec_idac_decode

`default_nettype wire

// ===== verilog/rec_axil_slave.sv
`default_nettype none

module rec_axil_slave
    import rec_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic [REC_ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [REC_DATA_W-1:0]   s_axi_wdata,
    input  wire logic [REC_DATA_W/8-1:0] s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [REC_ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [REC_DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    rec_regbus_if.slave                  bus
);

    logic                    aw_held_reg, aw_held_next;
    logic                    w_held_reg,  w_held_next;
    logic [REC_ADDR_W-1:0]   addr_reg,    addr_next;
    logic [REC_DATA_W-1:0]   data_reg,    data_next;
    logic [REC_DATA_W/8-1:0] strb_reg,    strb_next;
    logic                    bvalid_next, awready_next, wready_next;
    logic [1:0]              bresp_next,  rresp_next;
    rec_rd_state_t           rd_state_reg, rd_state_next;
    logic [REC_DATA_W-1:0]   rdata_next;
    logic                    fire;

    // Write fires once both halves are held and no response is pending
    assign fire        = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    assign bus.wr_en   = fire;
    assign bus.wr_addr = addr_reg;
    assign bus.wr_data = data_reg;
    assign bus.wr_strb = strb_reg;
    assign bus.rd_addr = s_axi_araddr;

    always_comb begin
        aw_held_next = aw_held_reg | (s_axi_awvalid & s_axi_awready);
        w_held_next  = w_held_reg | (s_axi_wvalid & s_axi_wready);
        addr_next    = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : addr_reg;
        data_next    = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : data_reg;
        strb_next    = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : strb_reg;
        bvalid_next  = s_axi_bvalid & ~s_axi_bready;
        bresp_next   = s_axi_bresp;
        if (fire) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = bus.wr_ok ? REC_RESP_OKAY : REC_RESP_SLVERR;
        end
        awready_next = ~aw_held_next & ~bvalid_next;
        wready_next  = ~w_held_next & ~bvalid_next;
    end

    always_comb begin
        rd_state_next = rd_state_reg;
        rdata_next    = s_axi_rdata;
        rresp_next    = s_axi_rresp;
        case (rd_state_reg)
            REC_RD_IDLE: begin
                if (s_axi_arvalid) begin
                    rd_state_next = REC_RD_RESP;
                    rdata_next    = bus.rd_ok ? bus.rd_data : '0;
                    rresp_next    = bus.rd_ok ? REC_RESP_OKAY : REC_RESP_SLVERR;
                end
            end
            REC_RD_RESP: begin
                if (s_axi_rready) begin
                    rd_state_next = REC_RD_IDLE;
                end
            end
            default: rd_state_next = REC_RD_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            addr_reg      <= '0;
            data_reg      <= '0;
            strb_reg      <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= REC_RESP_OKAY;
            rd_state_reg  <= REC_RD_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= REC_RESP_OKAY;
        end else begin
            aw_held_reg   <= aw_held_next;
            w_held_reg    <= w_held_next;
            addr_reg      <= addr_next;
            data_reg      <= data_next;
            strb_reg      <= strb_next;
            s_axi_awready <= awready_next;
            s_axi_wready  <= wready_next;
            s_axi_bvalid  <= bvalid_next;
            s_axi_bresp   <= bresp_next;
            rd_state_reg  <= rd_state_next;
            s_axi_arready <= (rd_state_next == REC_RD_IDLE);
            s_axi_rvalid  <= (rd_state_next == REC_RD_RESP);
            s_axi_rdata   <= rdata_next;
            s_axi_rresp   <= rresp_next;
        end
    end

endmodule : rec_axil_slave

`default_nettype wire

// ===== verilog/rec_ref_excite_cfg.sv
`default_nettype none

module rec_ref_excite_cfg
    import rec_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic [REC_ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]              s_axi_awprot,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [REC_DATA_W-1:0]   s_axi_wdata,
    input  wire logic [REC_DATA_W/8-1:0] s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [REC_ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]              s_axi_arprot,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [REC_DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic                    power_down_request,
    output logic                         ext_ref_monitor_enable,
    output logic                         pos_ref_buffer_bypass,
    output logic                         neg_ref_buffer_bypass,
    output logic [1:0]                   reference_select,
    output logic                         ref_use_first_pair,
    output logic                         ref_use_second_pair,
    output logic                         ref_use_internal,
    output logic [1:0]                   internal_ref_control,
    output logic                         internal_ref_powered,
    output logic [3:0]                   excitation_magnitude_code,
    output logic [REC_UA_W-1:0]          current_source_one_ua,
    output logic [REC_UA_W-1:0]          current_source_two_ua,
    output logic                         current_sources_active,
    output logic [3:0]                   current_source_one_route,
    output logic [3:0]                   current_source_two_route
);

    localparam logic [REC_ADDR_W-1:0] ADDR_REF    = {REC_IDX_REF, 2'b00};
    localparam logic [REC_ADDR_W-1:0] ADDR_MAG    = {REC_IDX_MAG, 2'b00};
    localparam logic [REC_ADDR_W-1:0] ADDR_ROUTE  = {REC_IDX_ROUTE, 2'b00};
    localparam logic [REC_ADDR_W-1:0] ADDR_STATUS = {REC_IDX_STATUS, 2'b00};

    rec_regbus_if bus ();

    rec_axil_slave u_slave (
        .clk           (clk),
        .srst          (srst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .bus           (bus)
    );

    // Stored register images
    logic [7:0] ref_reg,   ref_next;
    logic [7:0] mag_reg,   mag_next;
    logic [7:0] route_reg, route_next;
    logic [7:0] status_now;

    // Field views of the stored images
    rec_refsel_t sel_now;
    rec_refcon_t con_now;
    logic [3:0]  code_now;
    logic        ref_on_now;
    logic [REC_UA_W-1:0] ua_now;
    logic        src_on_now;
    logic        lane0;

    // Next values of the registered outputs
    logic              mon_next, pbuf_next, nbuf_next;
    logic [1:0]        sel_next, con_next;
    logic              first_next, second_next, internal_next, powered_next;
    logic [3:0]        code_next, route1_next, route2_next;
    logic [REC_UA_W-1:0] ua_next;
    logic              active_next;

    assign sel_now  = rec_refsel_t'(ref_reg[REC_SEL_LSB +: 2]);
    assign con_now  = rec_refcon_t'(ref_reg[REC_CON_LSB +: 2]);
    assign code_now = mag_reg[REC_MAG_LSB +: 4];
    assign lane0    = bus.wr_strb[0];

    rec_idac_decode u_decode (
        .code      (code_now),
        .microamps (ua_now),
        .active    (src_on_now)
    );

    // Internal source: sleeping code drops out while the converter is powered down
    always_comb begin
        case (con_now)
            REC_CON_ON_SLEEP: ref_on_now = ~power_down_request;
            REC_CON_ALWAYS:   ref_on_now = 1'b1;
            default:          ref_on_now = 1'b0;
        endcase
    end

    // Read-only summary of the block's own state and host mistakes
    always_comb begin
        status_now = 8'h00;
        status_now[REC_ST_REF_ON]    = ref_on_now;
        status_now[REC_ST_SEL_RSVD]  = (sel_now == REC_SEL_RESERVED);
        status_now[REC_ST_CON_RSVD]  = (con_now == REC_CON_RESERVED);
        status_now[REC_ST_SRC_NOREF] = src_on_now & ~ref_on_now;
        status_now[REC_ST_INT_BUF]   = (sel_now == REC_SEL_INTERNAL)
                                     & ~(ref_reg[REC_BIT_PBUF]
                                         & ref_reg[REC_BIT_NBUF]);
        status_now[REC_ST_RSVD_SET]  = ref_reg[REC_BIT_REF_RSVD]
                                     | ((mag_reg[7:4] & REC_MAG_RSVD_MASK) != 4'h0);
        status_now[REC_ST_SRC_ON]    = src_on_now;
    end

    // Register write path; only byte lane 0 carries register data
    always_comb begin
        ref_next   = ref_reg;
        mag_next   = mag_reg;
        route_next = route_reg;
        bus.wr_ok  = 1'b1;
        case (bus.wr_addr)
            ADDR_REF: begin
                if (bus.wr_en && lane0) begin
                    ref_next = bus.wr_data[7:0];
                end
            end
            ADDR_MAG: begin
                if (bus.wr_en && lane0) begin
                    mag_next = bus.wr_data[7:0];
                end
            end
            ADDR_ROUTE: begin
                if (bus.wr_en && lane0) begin
                    route_next = bus.wr_data[7:0];
                end
            end
            default: bus.wr_ok = 1'b0;
        endcase
    end

    // Register read path; upper bits read as zero
    always_comb begin
        bus.rd_data = '0;
        bus.rd_ok   = 1'b1;
        case (bus.rd_addr)
            ADDR_REF:    bus.rd_data[7:0] = ref_reg;
            ADDR_MAG:    bus.rd_data[7:0] = mag_reg;
            ADDR_ROUTE:  bus.rd_data[7:0] = route_reg;
            ADDR_STATUS: bus.rd_data[7:0] = status_now;
            default:     bus.rd_ok        = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ref_reg   <= REC_RST_REF;
            mag_reg   <= REC_RST_MAG;
            route_reg <= REC_RST_ROUTE;
        end else begin
            ref_reg   <= ref_next;
            mag_reg   <= mag_next;
            route_reg <= route_next;
        end
    end

    // Output values, one cycle behind the register images
    always_comb begin
        mon_next      = ref_reg[REC_BIT_MON];
        pbuf_next     = ref_reg[REC_BIT_PBUF];
        nbuf_next     = ref_reg[REC_BIT_NBUF];
        sel_next      = sel_now;
        con_next      = con_now;
        first_next    = (sel_now == REC_SEL_FIRST);
        second_next   = (sel_now == REC_SEL_SECOND);
        internal_next = (sel_now == REC_SEL_INTERNAL);
        powered_next  = ref_on_now;
        code_next     = code_now;
        ua_next       = ua_now;
        active_next   = src_on_now;
        route1_next   = route_reg[REC_ROUTE1_LSB +: 4];
        route2_next   = route_reg[REC_ROUTE2_LSB +: 4];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ext_ref_monitor_enable    <= REC_RST_REF[REC_BIT_MON];
            pos_ref_buffer_bypass     <= REC_RST_REF[REC_BIT_PBUF];
            neg_ref_buffer_bypass     <= REC_RST_REF[REC_BIT_NBUF];
            reference_select          <= REC_RST_REF[REC_SEL_LSB +: 2];
            ref_use_first_pair        <= 1'b1;
            ref_use_second_pair       <= 1'b0;
            ref_use_internal          <= 1'b0;
            internal_ref_control      <= REC_RST_REF[REC_CON_LSB +: 2];
            internal_ref_powered      <= 1'b0;
            excitation_magnitude_code <= REC_RST_MAG[REC_MAG_LSB +: 4];
            current_source_one_ua     <= '0;
            current_source_two_ua     <= '0;
            current_sources_active    <= 1'b0;
            current_source_one_route  <= REC_RST_ROUTE[REC_ROUTE1_LSB +: 4];
            current_source_two_route  <= REC_RST_ROUTE[REC_ROUTE2_LSB +: 4];
        end else begin
            ext_ref_monitor_enable    <= mon_next;
            pos_ref_buffer_bypass     <= pbuf_next;
            neg_ref_buffer_bypass     <= nbuf_next;
            reference_select          <= sel_next;
            ref_use_first_pair        <= first_next;
            ref_use_second_pair       <= second_next;
            ref_use_internal          <= internal_next;
            internal_ref_control      <= con_next;
            internal_ref_powered      <= powered_next;
            excitation_magnitude_code <= code_next;
            current_source_one_ua     <= ua_next;
            current_source_two_ua     <= ua_next;
            current_sources_active    <= active_next;
            current_source_one_route  <= route1_next;
            current_source_two_route  <= route2_next;
        end
    end

endmodule : rec_ref_excite_cfg

`default_nettype wire

// ===== tb/rec_cfg_sva.sv
`default_nettype none
module rec_cfg_sva import rec_pkg::*; (
    input wire logic                  clk,
    input wire logic                  srst,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready,
    input wire logic [REC_DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0]            reference_select,
    input wire logic                  ref_use_internal,
    input wire logic [1:0]            internal_ref_control,
    input wire logic                  internal_ref_powered,
    input wire logic [3:0]            excitation_magnitude_code,
    input wire logic [REC_UA_W-1:0]   current_source_one_ua,
    input wire logic [REC_UA_W-1:0]   current_source_two_ua,
    input wire logic                  current_sources_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Fields and decoded outputs leave the same register stage
    a_sel_internal: assert property (ref_use_internal == (reference_select == 2'h2))
        else $error("internal select flag wrong");
    a_ref_always: assert property (internal_ref_control == 2'h2 |-> internal_ref_powered)
        else $error("internal reference not powered");
    a_src_equal: assert property (current_source_one_ua == current_source_two_ua)
        else $error("current sources differ");
    a_code_off: assert property ((excitation_magnitude_code inside {4'h0, [4'ha:4'hf]}) |->
        current_source_one_ua == 12'h000) else $error("current not off");
    a_active_flag: assert property (current_sources_active == (current_source_two_ua != 0))
        else $error("active flag wrong");
    a_reset_vals: assert property ($fell(srst) |-> excitation_magnitude_code == 4'h0
        && reference_select == 2'h0) else $error("bad values after reset");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data not held");
endmodule // rec_cfg_sva
bind rec_ref_excite_cfg rec_cfg_sva u_sva (.clk, .srst, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .reference_select, .ref_use_internal,
    .internal_ref_control, .internal_ref_powered, .excitation_magnitude_code,
    .current_source_one_ua, .current_source_two_ua, .current_sources_active);
`default_nettype wire

// ===== tb/rec_ref_excite_cfg_bench.sv
`default_nettype none
module rec_ref_excite_cfg_bench import rec_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] A_REF = {REC_IDX_REF, 2'b00};
    localparam logic [7:0] A_MAG = {REC_IDX_MAG, 2'b00};
    localparam logic [7:0] A_RTE = {REC_IDX_ROUTE, 2'b00};
    localparam logic [7:0] A_ST  = {REC_IDX_STATUS, 2'b00};
    localparam logic [11:0] UA [16] = '{12'h000, 12'h00a, 12'h032, 12'h064, 12'h0fa, 12'h1f4,
        12'h2ee, 12'h3e8, 12'h5dc, 12'h7d0, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000};
    logic        clk = 1'b0, srst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        power_down_request = 1'b0, late = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        ext_ref_monitor_enable, pos_ref_buffer_bypass, neg_ref_buffer_bypass;
    logic        ref_use_first_pair, ref_use_second_pair, ref_use_internal;
    logic        internal_ref_powered, current_sources_active;
    logic [1:0]  s_axi_bresp, s_axi_rresp, reference_select, internal_ref_control;
    logic [31:0] s_axi_rdata;
    logic [3:0]  excitation_magnitude_code, current_source_one_route, current_source_two_route;
    logic [11:0] current_source_one_ua, current_source_two_ua;
    int          error_cnt = 0, n_compared = 0, cyc = 0;
    wire logic [6:0] ref_out = {ext_ref_monitor_enable, pos_ref_buffer_bypass,
        neg_ref_buffer_bypass, reference_select, internal_ref_control};
    wire logic [2:0] use_out = {ref_use_internal, ref_use_second_pair, ref_use_first_pair};
    rec_ref_excite_cfg uut (
        .clk, .srst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_down_request,
        .ext_ref_monitor_enable, .pos_ref_buffer_bypass, .neg_ref_buffer_bypass,
        .reference_select, .ref_use_first_pair, .ref_use_second_pair, .ref_use_internal,
        .internal_ref_control, .internal_ref_powered, .excitation_magnitude_code,
        .current_source_one_ua, .current_source_two_ua, .current_sources_active,
        .current_source_one_route, .current_source_two_route);
    always #5 clk = ~clk;
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Readies sampled at the falling edge equal what the next rising edge sees
    task automatic wr(input logic [7:0] a, d, input logic [3:0] s, input logic [1:0] er);
        logic       ra, rw, rb;
        logic [1:0] rs;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk);
            {ra, rw, rb, rs} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge clk);
            if (ra) s_axi_awvalid <= 1'b0;
            if (rw) s_axi_wvalid <= 1'b0;
        end while (!rb);
        s_axi_bready <= 1'b0;
        @(negedge clk);
        chk("bresp", er, rs);
    endtask
    task automatic rd(input logic [7:0] a, ed, input logic [1:0] er);
        logic        ra, rv;
        logic [31:0] d;
        logic [1:0]  rs;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !late;
        do begin
            @(negedge clk);
            {ra, rv, d, rs} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge clk);
            if (ra) s_axi_arvalid <= 1'b0;
            if (rv && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(rv && s_axi_rready));
        s_axi_rready <= 1'b0;
        @(negedge clk);
        chk("rdata", ed, d);
        chk("rresp", er, rs);
    endtask
    task automatic t_reset();
        rd(A_REF, REC_RST_REF, 2'h0);
        rd(A_MAG, REC_RST_MAG, 2'h0);
        rd(A_RTE, REC_RST_ROUTE, 2'h0);
        rd(A_ST, 8'h00, 2'h0);
        chk("route", 32'hff, {current_source_two_route, current_source_one_route});
        chk("refout", REC_RST_REF[6:0], ref_out);
    endtask
    task automatic t_fields();
        logic [3:0] k;
        logic [7:0] rv;
        logic       pw;
        wr(A_REF, 8'h3a, 4'hf, 2'h0);
        for (int i = 0; i < 16; i++) begin
            k = i[3:0];
            rv = {k[0], k[1], k[2], k[3], k};
            pw = k[1:0] == 2'h2 || (k[1:0] == 2'h1 && !k[2]);
            @(posedge clk);
            power_down_request <= k[2];
            wr(A_REF, rv, 4'hf, 2'h0);
            wr(A_MAG, {~k, k}, 4'hf, 2'h0);
            rd(A_ST, {1'b0, UA[k] != 0, k[0] | (~k != 4'h0), k[3:2] == 2'h2 && !(rv[5] && rv[4]),
                UA[k] != 0 && !pw, &k[1:0], &k[3:2], pw}, 2'h0);
            rd(A_REF, rv, 2'h0);
            rd(A_MAG, {~k, k}, 2'h0);
            chk("refout", rv[6:0], ref_out);
            chk("select", {k[3:2] == 2'h2, k[3:2] == 2'h1, k[3:2] == 2'h0}, use_out);
            chk("pwr", pw, internal_ref_powered);
            chk("ua", {UA[k], UA[k]}, {current_source_one_ua, current_source_two_ua});
            chk("active", UA[k] != 12'h000, current_sources_active);
            chk("code", k, excitation_magnitude_code);
        end
    endtask
    task automatic t_errs();
        wr(A_RTE, 8'h5a, 4'hf, 2'h0);
        chk("route", 32'h5a, {current_source_two_route, current_source_one_route});
        wr(8'h20, 8'h01, 4'hf, REC_RESP_SLVERR);
        rd(8'h20, 8'h00, REC_RESP_SLVERR);
        wr(A_ST, 8'h01, 4'hf, REC_RESP_SLVERR);
        wr(A_RTE, 8'h33, 4'h0, REC_RESP_OKAY);
        late = 1'b1;
        rd(A_RTE, 8'h5a, REC_RESP_OKAY);
        late = 1'b0;
    endtask
    task automatic t_rst2();
        wr(A_REF, 8'h6b, 4'hf, 2'h0);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(A_REF, REC_RST_REF, 2'h0);
        chk("select", 32'h1, use_out);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_fields();
        t_errs();
        t_rst2();
        close_out();
    end
endmodule // rec_ref_excite_cfg_bench
`default_nettype wire
